/* design/led_dimmer_cmd_regs.sv */
// command and fault-status register bank of the eight-channel led dimmer
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: mode 00 off, 01 on, 10 dim, 11 fade
// R2: low eight bits give on-fraction over 256
// R3: zero dimming value is stored as one
// R4: overheat forces both fault registers, raises flag
// R5: shutdown reads all ones, flag stays low
// R6: master ends special commands with own stop
// R7: repeated start behaves exactly like start
// R8: transfers run as eight bits plus ack
// R9: acknowledge write address and every data byte
// R10: data byte latched when its ack returns
// R11: latched data kept across repeated starts
// R12: stop commits latched data into registers
// R13: threshold codes update at the ack itself
// R14: ack read address; master acks but last
// R15: reads before stop show pending latch contents
// R16: open threshold bits 13:12, shorted 11:10
// R17: command bits 6:4 select the channel
// R18: all-channel read: switch, open, shorted status
// R19: switch follows most recently updated register
// R20: one status bit per channel, reset zero
// R21: status registers ignore writes, hardware only
module led_dimmer_cmd_regs #(
  parameter dimmer_pkg::setting_t SETTING_INIT = dimmer_pkg::SETTING_RST,
  parameter logic [7:0]           ALL_SW_INIT  = dimmer_pkg::ALL_SW_RST
) (
  input  wire logic                                           CLK,
  input  wire logic                                           RESET,
  input  wire logic                                           CE,
  input  wire logic                                           SCL_IN,
  input  wire logic                                           SDA_IN,
  output logic                                                SDA_OUT,
  output logic                                                SDA_OE,
  input  wire logic [dimmer_pkg::STRAP_W-1:0]                 ADDR_SEL,
  input  wire logic                                           OVERHEAT,
  input  wire logic                                           SHUTDOWN,
  input  wire logic [dimmer_pkg::NCH-1:0]                     OPEN_DETECT,
  input  wire logic [dimmer_pkg::NCH-1:0]                     SHORT_DETECT,
  output logic [dimmer_pkg::NCH*dimmer_pkg::SET_W-1:0]        CHANNEL_SETTING,
  output logic [dimmer_pkg::NCH-1:0]                          ALL_CHANNEL_SWITCH,
  output logic [dimmer_pkg::NCH-1:0]                          SETTING_DOMINANT,
  output logic [dimmer_pkg::NCH-1:0]                          OPEN_FAULT_STATUS,
  output logic [dimmer_pkg::NCH-1:0]                          SHORT_FAULT_STATUS,
  output logic                                                FAULT_FLAG
);
  import dimmer_pkg::*;

  typedef struct packed {
    // pin synchronisers, first stage read only by the second
    logic                           ot_m, ot_s, sd_m, sd_s;
    logic [NCH-1:0]                 opn_m, opn_s, sht_m, sht_s;
    logic [STRAP_W-1:0]             adr_m, adr_s;
    // transfer control
    ctl_state_t                     state;
    logic                           addr_ack;
    logic                           ack_en;
    logic                           tx_mode;
    logic [7:0]                     tx_byte;
    logic [1:0]                     rd_idx;
    logic [CMD_CH_W-1:0]            ch_sel;
    // holding latches, waiting for stop
    logic [7:0]                     ac_hold;
    logic                           ac_pend;
    logic [NCH-1:0][FIELD2_W-1:0]   mode_hold;
    logic [NCH-1:0]                 mode_pend;
    logic [NCH-1:0][DIM_W-1:0]      dim_hold;
    logic [NCH-1:0]                 dim_pend;
    logic [NCH-1:0]                 after_ac;
    // committed registers
    logic [NCH-1:0][SET_W-1:0]      setting;
    logic [7:0]                     all_sw;
    logic [NCH-1:0]                 dom;
    logic [NCH-1:0]                 open_st;
    logic [NCH-1:0]                 short_st;
    logic                           fault_flag;
    logic                           sda_out;
  } regs_t;

  regs_t st_r, st_nxt;

  i2c_link_if link ();

  i2c_bit_engine u_engine (
    .clk    (CLK),
    .reset  (RESET),
    .ce     (CE),
    .scl_in (SCL_IN),
    .sda_in (SDA_IN),
    .sda_oe (SDA_OE),
    .link   (link.ctrl)
  );

  // setting as the master sees it before stop: committed fields overlaid with pending ones
  function automatic setting_t pend_view(input regs_t r, input logic [CMD_CH_W-1:0] ch);
    setting_t s;
    s = r.setting[ch];
    if (r.mode_pend[ch]) s[MODE_LO +: FIELD2_W] = r.mode_hold[ch];
    if (r.dim_pend[ch]) s[DIM_LO +: DIM_W] = r.dim_hold[ch];
    pend_view = s;
  endfunction : pend_view

  // byte to shift out for a given read command and position
  function automatic logic [7:0] rd_byte(input regs_t r, input ctl_state_t st, input logic [1:0] idx);
    setting_t v;
    v = pend_view(r, r.ch_sel);
    rd_byte = RD_PAST_END;
    if (st == ST_AC_RD) begin
      // switch register first, then open faults, then shorted faults  (see R18)
      if (idx == RD_IDX0) rd_byte = r.ac_pend ? r.ac_hold : r.all_sw;  // see R15
      else if (idx == RD_IDX1) rd_byte = r.open_st;
      else if (idx == RD_IDX2) rd_byte = r.short_st;
    end else if (st == ST_SC_RD) begin
      if (idx == RD_IDX0) rd_byte = {2'h0, v[SET_W-1 -: RDHI_W]};
      else if (idx == RD_IDX1) rd_byte = v[DIM_LO +: DIM_W];
    end
  endfunction : rd_byte

  logic             match_ac;
  logic             match_sc;
  logic [CMD_CH_W-1:0] cmd_ch;
  ctl_state_t       rd_state;

  // address decode of the first byte after a start
  assign match_ac = (link.rx_byte[7:ADDR_HI_LO] == AC_ADDR_HI) && (link.rx_byte[STRAP_LO +: STRAP_W] == st_r.adr_s);
  assign match_sc = (link.rx_byte[7:ADDR_HI_LO] == SC_ADDR_HI) && (link.rx_byte[STRAP_LO +: STRAP_W] == st_r.adr_s);
  assign cmd_ch   = link.rx_byte[CMD_CH_LO +: CMD_CH_W];  // see R17
  assign rd_state = match_ac ? ST_AC_RD : ST_SC_RD;

  // next state of the whole bank
  always_comb begin
    st_nxt = st_r;
    st_nxt.ot_m  = OVERHEAT;
    st_nxt.ot_s  = st_r.ot_m;
    st_nxt.sd_m  = SHUTDOWN;
    st_nxt.sd_s  = st_r.sd_m;
    st_nxt.opn_m = OPEN_DETECT;
    st_nxt.opn_s = st_r.opn_m;
    st_nxt.sht_m = SHORT_DETECT;
    st_nxt.sht_s = st_r.sht_m;
    st_nxt.adr_m = ADDR_SEL;
    st_nxt.adr_s = st_r.adr_m;

    // status follows the detectors; bus writes never reach it  (see R20) (see R21)
    // overheat and shutdown both force all ones, only overheat without shutdown raises the flag
    st_nxt.open_st    = (st_r.ot_s || st_r.sd_s) ? FAULT_FORCED : st_r.opn_s;  // see R4 see R5
    st_nxt.short_st   = (st_r.ot_s || st_r.sd_s) ? FAULT_FORCED : st_r.sht_s;  // see R4 see R5
    st_nxt.fault_flag = st_r.ot_s & ~st_r.sd_s;  // see R4 see R5

    if (link.start_det) begin
      // latches untouched so a repeated start to another device loses nothing  (see R7) (see R11)
      st_nxt.state    = ST_ADDR;
      st_nxt.ack_en   = 1'b0;
      st_nxt.tx_mode  = 1'b0;
      st_nxt.addr_ack = 1'b0;
    end else if (link.stop_det) begin
      // commit everything latched since the last stop  (see R12)
      st_nxt.state   = ST_IDLE;
      st_nxt.ack_en  = 1'b0;
      st_nxt.tx_mode = 1'b0;
      if (st_r.ac_pend) begin
        st_nxt.all_sw = st_r.ac_hold;
        st_nxt.dom    = st_r.after_ac;  // see R19
      end else begin
        st_nxt.dom = st_r.dom | st_r.mode_pend | st_r.dim_pend;  // see R19
      end
      for (int i = 0; i < NCH; i++) begin
        if (st_r.mode_pend[i]) st_nxt.setting[i][MODE_LO +: FIELD2_W] = st_r.mode_hold[i];  // see R1
        if (st_r.dim_pend[i]) st_nxt.setting[i][DIM_LO +: DIM_W] = st_r.dim_hold[i];  // see R2
      end
      st_nxt.ac_pend   = 1'b0;
      st_nxt.mode_pend = '0;
      st_nxt.dim_pend  = '0;
      st_nxt.after_ac  = '0;
    end else if (link.byte_rx) begin
      if (st_r.state == ST_ADDR) begin
        // own address is acknowledged for both directions  (see R9) (see R14)
        st_nxt.ack_en   = match_ac | match_sc;
        st_nxt.addr_ack = 1'b1;
        if (!(match_ac || match_sc)) begin
          st_nxt.state = ST_SKIP;
        end else if (link.rx_byte[0]) begin
          st_nxt.state   = rd_state;
          st_nxt.tx_mode = 1'b1;
          st_nxt.rd_idx  = RD_IDX0;
          st_nxt.tx_byte = rd_byte(st_r, rd_state, RD_IDX0);
        end else begin
          st_nxt.state = match_ac ? ST_AC_WR : ST_SC_CMD;
        end
      end else begin
        st_nxt.ack_en = (st_r.state == ST_AC_WR) || (st_r.state == ST_SC_CMD) || (st_r.state == ST_SC_DIM);  // see R9
      end
    end else if (link.mst_ack) begin
      // master wants another byte; the slot after the last readable one reads all ones
      st_nxt.rd_idx  = (st_r.rd_idx == RD_IDX2) ? RD_IDX2 + 2'h1 : st_r.rd_idx + 2'h1;
      st_nxt.tx_byte = rd_byte(st_r, st_r.state, st_nxt.rd_idx);
    end else if (link.ack_done) begin
      if (st_r.addr_ack) begin
        st_nxt.addr_ack = 1'b0;
      end else begin
        // the byte moves into its latch as its acknowledge completes  (see R10)
        unique case (st_r.state)
          ST_AC_WR: begin
            st_nxt.ac_hold  = link.rx_byte;
            st_nxt.ac_pend  = 1'b1;
            st_nxt.after_ac = '0;
          end
          ST_SC_CMD: begin
            st_nxt.ch_sel             = cmd_ch;
            st_nxt.mode_hold[cmd_ch]  = link.rx_byte[CMD_MODE_LO +: FIELD2_W];  // see R1
            st_nxt.mode_pend[cmd_ch]  = 1'b1;
            st_nxt.after_ac[cmd_ch]   = 1'b1;
            // thresholds bypass the latch and land now  (see R13) (see R16)
            if (link.rx_byte[CMD_LONG]) begin
              st_nxt.setting[cmd_ch][SHORT_TH_LO +: FIELD2_W] = link.rx_byte[CMD_TH_LO +: FIELD2_W];
              st_nxt.state = ST_SC_DIM;
            end else begin
              st_nxt.setting[cmd_ch][OPEN_TH_LO +: FIELD2_W] = link.rx_byte[CMD_TH_LO +: FIELD2_W];
            end
          end
          ST_SC_DIM: begin
            st_nxt.dim_hold[st_r.ch_sel] = dim_fix(link.rx_byte);  // see R3
            st_nxt.dim_pend[st_r.ch_sel] = 1'b1;
            st_nxt.state                 = ST_SC_CMD;
          end
          ST_IDLE, ST_ADDR, ST_AC_RD, ST_SC_RD, ST_SKIP: begin
          end
        endcase
      end
    end
  end

  // single register stage for all state; the enable freezes everything
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r         <= '0;
      st_r.state   <= ST_IDLE;
      st_r.setting <= {NCH{SETTING_INIT}};
      st_r.all_sw  <= ALL_SW_INIT;
      st_r.adr_m   <= '0;
      // idle latches hold the smallest legal value, never a zero  (see R3)
      st_r.dim_hold <= {NCH{DIM_MIN}};
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign link.ack_en        = st_r.ack_en;
  assign link.tx_mode       = st_r.tx_mode;
  assign link.tx_byte       = st_r.tx_byte;
  assign SDA_OUT            = st_r.sda_out;
  assign CHANNEL_SETTING    = st_r.setting;
  assign ALL_CHANNEL_SWITCH = st_r.all_sw;
  assign SETTING_DOMINANT   = st_r.dom;
  assign OPEN_FAULT_STATUS  = st_r.open_st;
  assign SHORT_FAULT_STATUS = st_r.short_st;
  assign FAULT_FLAG         = st_r.fault_flag;

  // helper: any committed dimming field at zero
  function automatic logic has_zero_dim(input logic [NCH-1:0][SET_W-1:0] s);
    has_zero_dim = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (s[i][DIM_LO +: DIM_W] == DIM_ZERO) has_zero_dim = 1'b1;
    end
  endfunction : has_zero_dim

  // helper: any dimming holding latch at zero
  function automatic logic hold_zero(input logic [NCH-1:0][DIM_W-1:0] h);
    hold_zero = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (h[i] == DIM_ZERO) hold_zero = 1'b1;
    end
  endfunction : hold_zero

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_DIM_NEVER_ZERO: assert property (!has_zero_dim(st_r.setting) && !hold_zero(st_r.dim_hold)) // see R3
    else $error("dimming value of zero reached a register");
  AST_OVERHEAT_FORCE: assert property (CE && st_r.ot_s && !st_r.sd_s |=>
      OPEN_FAULT_STATUS == FAULT_FORCED && SHORT_FAULT_STATUS == FAULT_FORCED && FAULT_FLAG) // see R4
    else $error("overheat did not force status and flag");
  AST_SHUTDOWN_FORCE: assert property (CE && st_r.sd_s |=>
      OPEN_FAULT_STATUS == FAULT_FORCED && SHORT_FAULT_STATUS == FAULT_FORCED && !FAULT_FLAG) // see R5
    else $error("shutdown status or flag wrong");
  AST_STATUS_TRACKS: assert property (CE && !st_r.ot_s && !st_r.sd_s |=>
      OPEN_FAULT_STATUS == $past(st_r.opn_s) && SHORT_FAULT_STATUS == $past(st_r.sht_s)) // see R20
    else $error("fault status does not follow detectors");
  AST_WRITE_ACK: assert property (CE && link.byte_rx && !link.start_det && !link.stop_det &&
      (st_r.state == ST_AC_WR || st_r.state == ST_SC_CMD) |=> st_r.ack_en) // see R9
    else $error("write data byte not acknowledged");
  AST_HOLD_TILL_STOP: assert property (!(CE && link.stop_det) |=> $stable(ALL_CHANNEL_SWITCH)) // see R12
    else $error("switch register changed without stop");
  AST_STOP_COMMIT: assert property (CE && link.stop_det && st_r.ac_pend |=>
      ALL_CHANNEL_SWITCH == $past(st_r.ac_hold) && SETTING_DOMINANT == $past(st_r.after_ac) && !st_r.ac_pend) // see R19
    else $error("stop did not commit the all-channel latch");
  AST_RESTART_KEEPS: assert property (CE && link.start_det |=>
      st_r.state == ST_ADDR && st_r.ac_pend == $past(st_r.ac_pend) && st_r.mode_pend == $past(st_r.mode_pend)) // see R11
    else $error("repeated start disturbed the holding latches");
  AST_THRESH_NOW: assert property (CE && link.ack_done && !st_r.addr_ack && st_r.state == ST_SC_CMD &&
      !link.start_det && !link.stop_det && !link.rx_byte[CMD_LONG] |=>
      st_r.setting[$past(cmd_ch)][OPEN_TH_LO +: FIELD2_W] == $past(link.rx_byte[CMD_TH_LO +: FIELD2_W])) // see R13
    else $error("open threshold not updated at acknowledge");

  COV_AC_COMMIT: cover property (CE && link.stop_det && st_r.ac_pend);
  COV_SC_LONG:   cover property (CE && link.ack_done && st_r.state == ST_SC_DIM);
  COV_READ_MORE: cover property (CE && link.mst_ack && st_r.state == ST_AC_RD);
  COV_OVERHEAT:  cover property (FAULT_FLAG);
endmodule : led_dimmer_cmd_regs
`default_nettype wire

/* design/dimmer_pkg.sv */
// shared constants, field layout and types of the led dimmer command register bank
package dimmer_pkg;
  localparam int NCH         = 8;
  localparam int SET_W       = 14;
  // channel setting register field layout
  localparam int OPEN_TH_LO  = 12;
  localparam int SHORT_TH_LO = 10;
  localparam int MODE_LO     = 8;
  localparam int DIM_LO      = 0;
  localparam int FIELD2_W    = 2;
  localparam int DIM_W       = 8;
  localparam int RDHI_W      = 6;
  // switch mode codes
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_ON       = 2'h1;
  localparam logic [1:0] MODE_DIM      = 2'h2;
  localparam logic [1:0] MODE_DIM_FADE = 2'h3;
  // reset and forced values
  localparam logic [SET_W-1:0] SETTING_RST  = 14'h3101;
  localparam logic [7:0]       ALL_SW_RST   = 8'hFF;
  localparam logic [7:0]       FAULT_FORCED = 8'hFF;
  localparam logic [7:0]       RD_PAST_END  = 8'hFF;
  localparam logic [7:0]       DIM_ZERO     = 8'h00;
  localparam logic [7:0]       DIM_MIN      = 8'h01;
  // bus address: three fixed bits, four strap bits, direction bit
  localparam logic [2:0] AC_ADDR_HI = 3'h2;
  localparam logic [2:0] SC_ADDR_HI = 3'h3;
  localparam int         ADDR_HI_LO = 5;
  localparam int         STRAP_LO   = 1;
  localparam int         STRAP_W    = 4;
  // command byte layout
  localparam int CMD_LONG    = 7;
  localparam int CMD_CH_LO   = 4;
  localparam int CMD_CH_W    = 3;
  localparam int CMD_TH_LO   = 2;
  localparam int CMD_MODE_LO = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // read byte order
  localparam logic [1:0] RD_IDX0 = 2'h0;
  localparam logic [1:0] RD_IDX1 = 2'h1;
  localparam logic [1:0] RD_IDX2 = 2'h2;

  typedef logic [SET_W-1:0] setting_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AC_WR, ST_SC_CMD, ST_SC_DIM, ST_AC_RD, ST_SC_RD, ST_SKIP} ctl_state_t;

  // an all-zero dimming value is stored as the smallest legal one
  function automatic logic [7:0] dim_fix(input logic [7:0] v);
    dim_fix = (v == DIM_ZERO) ? DIM_MIN : v;
  endfunction : dim_fix
endpackage : dimmer_pkg

/* design/i2c_link_if.sv */
// byte-level link between the serial bit engine and the register controller
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic       start_det;
  logic       stop_det;
  logic       byte_rx;
  logic       ack_done;
  logic       mst_ack;
  logic [7:0] rx_byte;
  logic       ack_en;
  logic       tx_mode;
  logic [7:0] tx_byte;
  modport engine (output start_det, stop_det, byte_rx, ack_done, mst_ack, rx_byte,
                  input  ack_en, tx_mode, tx_byte);
  modport ctrl   (input  start_det, stop_det, byte_rx, ack_done, mst_ack, rx_byte,
                  output ack_en, tx_mode, tx_byte);
endinterface : i2c_link_if
`default_nettype wire

/* design/i2c_bit_engine.sv */
// serial bit engine: pin synchronisers, start/stop detection, nine-bit framing
`timescale 1ns/1ps
`default_nettype none
module i2c_bit_engine (
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   ce,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_oe,
  i2c_link_if.engine  link
);
  import dimmer_pkg::*;

  typedef struct packed {
    logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic       active, in_ack, tx_run, oe;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       start_p, stop_p, byte_p, ack_p, mack_p;
  } eng_t;

  eng_t st_r, st_nxt;
  logic scl_rise;
  logic scl_fall;

  // one pass per clock; start and stop outrank data edges
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_m = scl_in;
    st_nxt.scl_s = st_r.scl_m;
    st_nxt.scl_d = st_r.scl_s;
    st_nxt.sda_m = sda_in;
    st_nxt.sda_s = st_r.sda_m;
    st_nxt.sda_d = st_r.sda_s;
    {st_nxt.start_p, st_nxt.stop_p, st_nxt.byte_p, st_nxt.ack_p, st_nxt.mack_p} = '0;
    scl_rise = st_r.scl_s & ~st_r.scl_d;
    scl_fall = ~st_r.scl_s & st_r.scl_d;
    if (st_r.scl_s && st_r.scl_d && st_r.sda_d && !st_r.sda_s) begin
      // repeated start restarts framing just like a start  (see R7)
      {st_nxt.active, st_nxt.in_ack, st_nxt.tx_run, st_nxt.oe} = 4'h8;
      st_nxt.bit_cnt = '0;
      st_nxt.start_p = 1'b1;
    end else if (st_r.scl_s && st_r.scl_d && !st_r.sda_d && st_r.sda_s) begin
      {st_nxt.active, st_nxt.in_ack, st_nxt.tx_run, st_nxt.oe} = '0;
      st_nxt.stop_p = 1'b1;
    end else if (st_r.active && scl_rise) begin
      if (st_r.bit_cnt < BYTE_BITS) begin
        // eight data bits msb first, then the acknowledge slot  (see R8)
        st_nxt.shreg   = {st_r.shreg[6:0], st_r.sda_s};
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        st_nxt.byte_p  = (st_r.bit_cnt == BYTE_BITS - 4'h1) && !st_r.tx_run;
      end else if (st_r.tx_run) begin
        // master acks every byte but the last  (see R14)
        st_nxt.mack_p = ~st_r.sda_s;
        st_nxt.active = ~st_r.sda_s;
      end
    end else if (st_r.active && scl_fall) begin
      if (st_r.bit_cnt == BYTE_BITS && !st_r.in_ack) begin
        st_nxt.in_ack = 1'b1;
        st_nxt.oe     = ~st_r.tx_run & link.ack_en;
      end else if (st_r.in_ack) begin
        st_nxt.in_ack  = 1'b0;
        st_nxt.bit_cnt = '0;
        st_nxt.ack_p   = ~st_r.tx_run & st_r.oe;
        st_nxt.tx_run  = link.tx_mode;
        st_nxt.oe      = link.tx_mode & ~link.tx_byte[7];
        // an unacknowledged byte drops us off the bus until the next start
        if (!st_r.tx_run && !st_r.oe) st_nxt.active = 1'b0;
      end else if (st_r.tx_run) begin
        st_nxt.oe = ~link.tx_byte[3'(BYTE_BITS - 4'h1 - st_r.bit_cnt)];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      {st_r.scl_m, st_r.scl_s, st_r.scl_d, st_r.sda_m, st_r.sda_s, st_r.sda_d} <= 6'h3F;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sda_oe         = st_r.oe;
  assign link.start_det = st_r.start_p;
  assign link.stop_det  = st_r.stop_p;
  assign link.byte_rx   = st_r.byte_p;
  assign link.ack_done  = st_r.ack_p;
  assign link.mst_ack   = st_r.mack_p;
  assign link.rx_byte   = st_r.shreg;
endmodule : i2c_bit_engine
`default_nettype wire

/* tb/bus_master.sv */
// behavioural bus master that drives the dimmer's serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  input  wire logic CLK,
  input  wire logic SDA_OE,
  output var logic  SCL,
  output logic      SDA
);
  logic drv_low;
  // open-drain wire: pull-up unless either party pulls low
  assign SDA = ~(drv_low | SDA_OE);
  initial begin
    SCL     = 1'b1;
    drv_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge CLK);
  endtask : wt
  // data released before the clock rises, so this also gives a repeated start
  task automatic start();
    drv_low = 1'b0;
    wt(4);
    SCL = 1'b1;
    wt(8);
    drv_low = 1'b1;
    wt(8);
    SCL = 1'b0;
    wt(4);
  endtask : start
  task automatic stop();
    drv_low = 1'b1;
    wt(4);
    SCL = 1'b1;
    wt(8);
    drv_low = 1'b0;
    wt(8);
  endtask : stop
  // four-cycle phases leave a cycle of margin over the three-cycle pin latency
  task automatic bit_cell(input logic b, output logic r);
    drv_low = ~b;
    wt(4);
    SCL = 1'b1;
    wt(4);
    r = SDA;
    wt(4);
    SCL = 1'b0;
    wt(4);
  endtask : bit_cell
  // eight data bits, then the acknowledge of the receiving party
  task automatic xfer(input logic [7:0] wd, input logic mack, output logic [7:0] rd, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(wd[i], r);
      rd[i] = r;
    end
    bit_cell(~mack, r);
    ack = ~r;
  endtask : xfer
endmodule : bus_master
`default_nettype wire

/* tb/tb_top.sv */
// self-checking testbench of the led dimmer command register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dimmer_pkg::*;
  localparam logic [3:0] STRAP = 4'hA;
  localparam int         LIMIT = 20000;
  logic                 clk, reset, scl, sda, sda_oe, overheat, shutdown, flag, ack, ce, sda_out;
  logic [3:0]           strap;
  logic [7:0]           open_det, short_det, all_sw, dominant, open_st, short_st, rd;
  logic [NCH*SET_W-1:0] setting;
  int                   miscompares, check_count, cyc;
  bus_master bus_master_inst (.CLK(clk), .SDA_OE(sda_oe), .SCL(scl), .SDA(sda));
  led_dimmer_cmd_regs led_dimmer_cmd_regs_inst (.CLK(clk), .RESET(reset), .CE(ce), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(strap), .OVERHEAT(overheat), .SHUTDOWN(shutdown),
    .OPEN_DETECT(open_det), .SHORT_DETECT(short_det), .CHANNEL_SETTING(setting), .ALL_CHANNEL_SWITCH(all_sw),
    .SETTING_DOMINANT(dominant), .OPEN_FAULT_STATUS(open_st), .SHORT_FAULT_STATUS(short_st), .FAULT_FLAG(flag));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // a hung handshake would otherwise stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    bus_master_inst.xfer(d, 1'b0, rd, ack);
    chk("ack", {15'h0, exp_ack}, {15'h0, ack});
  endtask : wr
  task automatic rdb(input logic last, input logic [7:0] exp);
    bus_master_inst.xfer(8'hFF, ~last, rd, ack);
    chk("read byte", {8'h0, exp}, {8'h0, rd});
  endtask : rdb
  function automatic logic [15:0] chan(input int c);
    chan = {2'b0, setting[c*SET_W +: SET_W]};
  endfunction : chan
  initial begin
    {reset, overheat, shutdown, open_det, short_det} = {1'b1, 18'h0};
    {miscompares, check_count, cyc} = '0;
    {ce, strap} = {1'b1, STRAP};
    repeat (16) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    bus_master_inst.wt(4);
    for (int c = 0; c < NCH; c++) chk("reset setting", {2'b0, SETTING_RST}, chan(c));
    chk("reset switch", {8'h0, ALL_SW_RST}, {8'h0, all_sw});
    chk("reset status", 16'h0, {open_st, short_st});
    chk("sda out", 16'h0, {15'h0, sda_out});
    $display("test reset finished");
    // all-channel write, foreign address, then read-back before commit
    bus_master_inst.start();
    wr({AC_ADDR_HI, STRAP, 1'b0}, 1'b1);
    wr(8'h5A, 1'b1);
    bus_master_inst.start();
    wr({AC_ADDR_HI, ~STRAP, 1'b0}, 1'b0);
    bus_master_inst.start();
    wr({AC_ADDR_HI, STRAP, 1'b1}, 1'b1);
    rdb(1'b0, 8'h5A);
    rdb(1'b0, 8'h00);
    rdb(1'b1, 8'h00);
    chk("switch before stop", {8'h0, ALL_SW_RST}, {8'h0, all_sw});
    bus_master_inst.stop();
    bus_master_inst.wt(8);
    chk("switch at stop", 16'h005A, {8'h0, all_sw});
    $display("test all-channel write finished");
    // long format into every channel; thresholds move at the ack, the rest at stop
    bus_master_inst.start();
    wr({SC_ADDR_HI, STRAP, 1'b0}, 1'b1);
    for (int c = 0; c < NCH; c++) begin
      wr({1'b1, c[2:0], ~c[1:0], c[1:0]}, 1'b1);
      wr(8'(c * 36), 1'b1);
      bus_master_inst.wt(8);
      chk("threshold at ack", {4'h3, ~c[1:0], MODE_ON, DIM_MIN}, chan(c));
    end
    bus_master_inst.start();
    wr({SC_ADDR_HI, STRAP, 1'b1}, 1'b1);
    rdb(1'b0, 8'h33);
    rdb(1'b1, 8'hFC);
    bus_master_inst.stop();
    bus_master_inst.wt(8);
    for (int c = 0; c < NCH; c++) chk("committed", {4'h3, ~c[1:0], c[1:0], (c == 0) ? DIM_MIN : 8'(c * 36)}, chan(c));
    chk("dominant", 16'h00FF, {8'h0, dominant});
    $display("test long format finished");
    // short format on channel two, then an all-channel write takes back control
    bus_master_inst.start();
    wr({SC_ADDR_HI, STRAP, 1'b0}, 1'b1);
    wr({1'b0, 3'h2, 2'b01, MODE_OFF}, 1'b1);
    bus_master_inst.wt(8);
    chk("open threshold at ack", {4'h1, 2'b01, MODE_DIM, 8'h48}, chan(2));
    bus_master_inst.stop();
    bus_master_inst.start();
    wr({AC_ADDR_HI, STRAP, 1'b0}, 1'b1);
    wr(8'h0F, 1'b1);
    bus_master_inst.stop();
    bus_master_inst.wt(8);
    chk("short committed", {4'h1, 2'b01, MODE_OFF, 8'h48}, chan(2));
    chk("switch dominant", 16'h0F00, {all_sw, dominant});
    $display("test short format finished");
    // live faults, overheat, then shutdown on top of it
    {open_det, short_det} = 16'h813C;
    bus_master_inst.wt(8);
    chk("fault status", 16'h813C, {open_st, short_st});
    ce = 1'b0;
    {open_det, short_det} = 16'h0;
    bus_master_inst.wt(8);
    chk("frozen status", 16'h813C, {open_st, short_st});
    ce = 1'b1;
    bus_master_inst.wt(8);
    chk("cleared status", 16'h0, {open_st, short_st});
    chk("flag idle", 16'h0, {15'h0, flag});
    overheat = 1'b1;
    bus_master_inst.wt(8);
    chk("overheat status", 16'hFFFF, {open_st, short_st});
    chk("overheat flag", 16'h1, {15'h0, flag});
    bus_master_inst.start();
    wr({AC_ADDR_HI, STRAP, 1'b1}, 1'b1);
    rdb(1'b0, 8'h0F);
    rdb(1'b0, 8'hFF);
    rdb(1'b1, 8'hFF);
    bus_master_inst.stop();
    shutdown = 1'b1;
    bus_master_inst.wt(8);
    chk("shutdown status", 16'hFFFF, {open_st, short_st});
    chk("shutdown flag", 16'h0, {15'h0, flag});
    $display("test faults finished");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
